// ---- hdl/sips_shifter.sv ----
// eight-stage serial-in parallel-out shifter with word fifo on its output
// assumes all pin inputs are synchronous to i_clk
//
// Behaviour
// [R1] eight chained stages are fed from one line made from two feed pins.
// [R2] the feed line is high only when both feed pins are high.
// [R3] stages change, apart from clearing, only on a rising edge of the shift clock pin.
// [R4] on a rising edge the first stage takes the feed line and each other stage its neighbour.
// [R5] on a rising edge the old last-stage value is dropped with no carry-out.
// [R6] while the clear pin is low all stages go to zero, over clock and feed pins.
// [R7] with clear high and no rising edge every stage holds its level.
// [R8] each rising edge moves the pattern one place toward the last stage.
// [R9] the feed pins may change any time and are looked at only at the rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "sips_regs.svh"

module sips_shifter (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  // serial pins
  input  wire logic                 i_feed_one,
  input  wire logic                 i_feed_two,
  input  wire logic                 i_shift_clk,
  input  wire logic                 i_zero_all_n,
  // parallel outputs
  output logic [`SIPS_STAGES-1:0]   o_stage,
  output logic                      o_stage_out_one,
  output logic                      o_stage_out_last,
  // word stream
  output logic [`SIPS_STAGES-1:0]   o_word_data,
  output logic                      o_word_valid,
  input  wire logic                 i_word_ready,
  output logic                      o_push_ready,
  output logic                      o_overflow
);
  sips_pkg::sips_word_t stage_reg;
  sips_pkg::sips_word_t stage_next;
  logic                 clk_prev_reg;
  logic                 clk_prev_next;
  logic                 push_reg;
  logic                 push_next;
  logic                 ovf_reg;
  logic                 ovf_next;
  logic                 feed_line;
  logic                 rise;

  sips_stream_if #(.WIDTH(`SIPS_STAGES)) to_fifo ();
  sips_stream_if #(.WIDTH(`SIPS_STAGES)) from_fifo ();

  // ----------------------------------------
  // feed gating and edge detect
  // ----------------------------------------
  assign feed_line = i_feed_one & i_feed_two; // [R2]
  assign rise      = i_shift_clk & ~clk_prev_reg; // [R3] [R9]

  // ----------------------------------------
  // stage chain
  // ----------------------------------------
  always_comb begin
    stage_next    = stage_reg; // [R7]
    clk_prev_next = i_shift_clk;
    push_next     = 1'b0;
    ovf_next      = ovf_reg;
    if (!i_zero_all_n) begin
      stage_next = `SIPS_STAGE_RESET; // [R6]
    end else if (rise) begin
      stage_next = {stage_reg[`SIPS_STAGES-2:0], feed_line}; // [R1] [R4] [R5] [R8]
      push_next  = 1'b1;
    end
    if (push_reg && !to_fifo.ready) begin
      ovf_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      stage_reg    <= `SIPS_STAGE_RESET;
      clk_prev_reg <= 1'b0;
      push_reg     <= 1'b0;
      ovf_reg      <= 1'b0;
    end else begin
      stage_reg    <= stage_next;
      clk_prev_reg <= clk_prev_next;
      push_reg     <= push_next;
      ovf_reg      <= ovf_next;
    end
  end

  // ----------------------------------------
  // word fifo
  // ----------------------------------------
  assign to_fifo.data    = stage_reg;
  assign to_fifo.valid   = push_reg;
  assign from_fifo.ready = i_word_ready;

  sips_fifo #(
    .WIDTH (`SIPS_STAGES),
    .DEPTH (`SIPS_FIFO_DEPTH)
  ) u_fifo (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .s_in   (to_fifo),
    .s_out  (from_fifo)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_stage          = stage_reg;
  assign o_stage_out_one  = stage_reg[0];
  assign o_stage_out_last = stage_reg[`SIPS_STAGES-1];
  assign o_word_data      = from_fifo.data;
  assign o_word_valid     = from_fifo.valid;
  assign o_push_ready     = to_fifo.ready;
  assign o_overflow       = ovf_reg;
endmodule : sips_shifter

`default_nettype wire

// ---- hdl/sips_regs.svh ----
// constants for the serial-in parallel-out shifter
// assumes inclusion by bare name from the shifter files
`ifndef SIPS_REGS_SVH
`define SIPS_REGS_SVH

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define SIPS_STAGES      8
`define SIPS_FIFO_DEPTH  8
`define SIPS_STAGE_RESET 8'h00

`endif

// ---- hdl/sips_pkg.sv ----
// types for the serial-in parallel-out shifter
// assumes the constants header is compiled alongside
`default_nettype none
`include "sips_regs.svh"

package sips_pkg;
  typedef logic [`SIPS_STAGES-1:0] sips_word_t;
endpackage : sips_pkg

`default_nettype wire

// ---- hdl/sips_stream_if.sv ----
// valid/ready word stream between the shifter and its fifo
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none

interface sips_stream_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : sips_stream_if

`default_nettype wire

// ---- hdl/sips_fifo.sv ----
// word fifo with valid/ready on both sides
// assumes synchronous active-low reset on i_clk
`timescale 1ns/1ps
`default_nettype none

module sips_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // streams
  sips_stream_if.snk s_in,
  sips_stream_if.src s_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      wptr_next;
  logic [AW:0]      rptr_reg;
  logic [AW:0]      rptr_next;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // ----------------------------------------
  // flags and handshakes
  // ----------------------------------------
  assign empty       = (wptr_reg == rptr_reg);
  assign full        = (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]) && (wptr_reg[AW] != rptr_reg[AW]);
  assign s_in.ready  = !full;
  assign s_out.valid = !empty;
  assign s_out.data  = mem_reg[rptr_reg[AW-1:0]];
  assign push        = s_in.valid && !full;
  assign pop         = s_out.ready && !empty;

  always_comb begin
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    if (push) begin
      wptr_next = wptr_reg + 1'b1;
    end
    if (pop) begin
      rptr_next = rptr_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wptr_reg[AW-1:0]] <= s_in.data;
    end
  end
endmodule : sips_fifo

`default_nettype wire

// ---- sim/sips_props.sv ----
// assertions on the shifter top-level pins
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "sips_regs.svh"
module sips_props (
  input wire logic                    i_clk, i_rstn, i_feed_one, i_feed_two,
  input wire logic                    i_shift_clk, i_zero_all_n,
  input wire logic [`SIPS_STAGES-1:0] o_stage,
  input wire logic                    o_stage_out_one, o_stage_out_last, o_overflow
);
  logic sc_prev_reg;
  logic rise;
  always_ff @(posedge i_clk) sc_prev_reg <= i_rstn ? i_shift_clk : 1'b0;
  assign rise = i_zero_all_n & i_shift_clk & ~sc_prev_reg;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  shift_move_a: assert property (rise |=>
    o_stage == {$past(o_stage[6:0]), $past(i_feed_one & i_feed_two)}) else $error("bad shift");
  clear_zero_a: assert property (!i_zero_all_n |=> o_stage == 8'h00) else $error("no clear");
  hold_level_a: assert property (i_zero_all_n && !rise |=> $stable(o_stage))
    else $error("stage moved");
  shift_only_a: assert property ($past(i_rstn) && $changed(o_stage) |->
    $past(rise) || !$past(i_zero_all_n)) else $error("change off edge");
  gate_low_a: assert property (rise && !(i_feed_one && i_feed_two) |=> !o_stage_out_one)
    else $error("gate low");
  gate_high_a: assert property (rise && i_feed_one && i_feed_two |=> o_stage_out_one)
    else $error("gate high");
  out_one_a: assert property (o_stage_out_one == o_stage[0] &&
    o_stage_out_last == o_stage[`SIPS_STAGES-1]) else $error("end pins");
  out_last_a: assert property (rise |=> o_stage_out_last == $past(o_stage[6]))
    else $error("last pin");
  overflow_stick_a: assert property (o_overflow |=> o_overflow) else $error("flag fell");
endmodule : sips_props
bind sips_shifter sips_props u_props (.i_clk(i_clk), .i_rstn(i_rstn), .i_feed_one(i_feed_one),
  .i_feed_two(i_feed_two), .i_shift_clk(i_shift_clk), .i_zero_all_n(i_zero_all_n),
  .o_stage(o_stage), .o_stage_out_one(o_stage_out_one), .o_stage_out_last(o_stage_out_last),
  .o_overflow(o_overflow));
`default_nettype wire

// ---- sim/sips_host.sv ----
// host model driving feed, shift clock and clear pins
// assumes tasks are called just after a rising edge of i_clk
`timescale 1ns/1ps
`default_nettype none
module sips_host (
  input  wire logic i_clk,
  output logic      o_feed_one, o_feed_two, o_shift_clk, o_zero_all_n
);
  initial {o_feed_one, o_feed_two, o_shift_clk, o_zero_all_n} = 4'b0001;
  task shift(input logic a, input logic b);
    @(posedge i_clk) #1;
    o_feed_one = a;
    o_feed_two = b;
    o_shift_clk = 1'b1;
    @(posedge i_clk) #1;
    o_shift_clk = 1'b0;
    o_feed_one = ~a;
    o_feed_two = ~b;
    @(posedge i_clk) #1;
  endtask : shift
  task clear();
    @(posedge i_clk) #1;
    {o_feed_one, o_feed_two, o_shift_clk, o_zero_all_n} = 4'b1110;
    @(posedge i_clk) #1;
    o_zero_all_n = 1'b1;
    @(posedge i_clk) #1;
    o_shift_clk = 1'b0;
    @(posedge i_clk) #1;
  endtask : clear
endmodule : sips_host
`default_nettype wire

// ---- sim/serial_in_parallel_out_shifter_tb.sv ----
// self-checking bench for the shifter and its word fifo
// assumes the host model and the checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module serial_in_parallel_out_shifter_tb;
  logic       clk = 0, rstn = 0, rdy = 0;
  wire logic  f1, f2, sc, zn, oo, ol, wv, pr, ov;
  wire logic [7:0] st, wd;
  logic [7:0] exp = 8'h00, q[$];
  int         error_cnt = 0, cmp_count = 0;
  always #4 clk = ~clk;
  sips_host u_host (.i_clk(clk), .o_feed_one(f1), .o_feed_two(f2), .o_shift_clk(sc),
    .o_zero_all_n(zn));
  sips_shifter i_dut (.i_clk(clk), .i_rstn(rstn), .i_feed_one(f1), .i_feed_two(f2),
    .i_shift_clk(sc), .i_zero_all_n(zn), .o_stage(st), .o_stage_out_one(oo),
    .o_stage_out_last(ol), .o_word_data(wd), .o_word_valid(wv), .i_word_ready(rdy),
    .o_push_ready(pr), .o_overflow(ov));
  task chk(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task sh(input logic a, input logic b);
    u_host.shift(a, b);
    exp = {exp[6:0], a & b};
    if (q.size() < 8) q.push_back(exp);
    chk(st, exp);
    chk(oo, a & b);
    chk(ol, exp[7]);
  endtask : sh
  task t_fill();
    logic [7:0] p;
    p = 8'hA5;
    for (int i = 7; i >= 0; i--) sh(p[i], 1'b1);
    chk(st, 8'hA5);
    chk(pr, 0);
    chk(ov, 0);
  endtask : t_fill
  task t_gate();
    for (int i = 0; i < 4; i++) sh(i[1], i[0]);
    chk(ov, 1);
  endtask : t_gate
  task t_clear();
    u_host.clear();
    exp = 8'h00;
    chk(st, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk(st, 8'h00);
  endtask : t_clear
  task t_drain();
    rdy = 1;
    repeat (8) begin
      chk(wv, 1);
      chk(wd, q.pop_front());
      @(posedge clk) #1;
    end
    chk(wv, 0);
  endtask : t_drain
  task end_sim();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  initial begin
    #20000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rstn = 1;
    t_fill();
    t_gate();
    t_clear();
    t_drain();
    end_sim();
  end
endmodule : serial_in_parallel_out_shifter_tb
`default_nettype wire
